// file: rtl/assb_pkg.sv
// shared constants and types for the async serial port with baud generator
package assb_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_TXD = 8'h08;
  localparam logic [7:0] ADDR_TXSTA = 8'h0c;
  localparam logic [7:0] ADDR_RXD = 8'h10;
  localparam logic [7:0] ADDR_RXSTA = 8'h14;
  localparam logic [7:0] ADDR_SYSCLK = 8'h18;

  localparam int CTRL_ENRX = 6;
  localparam int CTRL_ENTX = 5;
  localparam int CTRL_RATE_LSB = 0;
  localparam int CMD_XSEL = 7;
  localparam int CMD_RCSEL_LSB = 3;
  localparam int CMD_PM = 2;
  localparam int CMD_PE = 1;
  localparam int CMD_WL = 0;
  localparam int SYSCLK_EXT = 0;
  localparam int SYSCLK_XEN = 1;
  localparam int TXSTA_ACTIVE = 1;
  localparam int TXSTA_LOADED = 0;

  localparam logic [7:0] CTRL_RST = 8'h05;
  localparam logic [7:0] CMD_RST = 8'h01;
  localparam logic [7:0] SYSCLK_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  localparam int IRQ_TX_LINE = 1;
  localparam int IRQ_RX_LINE = 0;

  localparam int PERIOD_W = 16;
  localparam logic [31:0] RC_BIT_DIV = 32'h0000_0010;
  localparam logic [15:0] XTAL_BIT_DIV = 16'h000e;
  localparam logic [4:0] RC_TOP_SHIFT = 5'h07;
  localparam int SRC_RC = 0;
  localparam int SRC_EXT = 1;
  localparam int SRC_XTAL = 2;

  typedef struct packed {
    logic xtal_sel;
    logic ext_choice;
    logic xtal_en;
    logic [2:0] rc_presc;
    logic [2:0] rate;
  } assb_baud_cfg_t;

  typedef struct packed {
    logic serr;
    logic perr;
    logic ferr;
    logic oerr;
    logic busy;
    logic loaded;
  } assb_rx_sta_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} assb_rx_state_t;
endpackage : assb_pkg

// file: rtl/assb_baud_gen.sv
// clock source selection, synchronisation and bit period generation
`timescale 1ns/1ps
module assb_baud_gen (
  input wire logic clk,
  input wire logic srst,
  input wire assb_pkg::assb_baud_cfg_t cfg,
  input wire logic [2:0] osc_pins,
  output logic src_tick,
  output logic [assb_pkg::PERIOD_W-1:0] bit_period
);
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] rise;
  logic tick_d;
  logic [4:0] rc_shift;
  logic [31:0] rc_period;
  logic [assb_pkg::PERIOD_W-1:0] period_d;

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk) begin
        if (srst) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
        end else begin
          s1_q[i] <= osc_pins[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
        end
      end
      assign rise[i] = s2_q[i] & ~s3_q[i];
    end
  endgenerate

  always_comb begin
    tick_d = 1'b0;
    if (cfg.xtal_sel) begin
      tick_d = cfg.xtal_en & rise[assb_pkg::SRC_XTAL];
    end else if (cfg.ext_choice) begin
      tick_d = rise[assb_pkg::SRC_EXT];
    end else begin
      tick_d = rise[assb_pkg::SRC_RC];
    end
  end

  // each prescaler step adds a halving, each lower rate code one more
  assign rc_shift = assb_pkg::RC_TOP_SHIFT - {2'b00, cfg.rate} + {2'b00, cfg.rc_presc};
  assign rc_period = assb_pkg::RC_BIT_DIV << rc_shift;

  always_comb begin
    period_d = rc_period[assb_pkg::PERIOD_W-1:0];
    if (cfg.xtal_sel) begin
      // 14 crystal ticks per 2400 baud bit, about -2.48 percent off nominal
      period_d = assb_pkg::XTAL_BIT_DIV << (2'h3 - cfg.rate[1:0]);
    end else if (cfg.ext_choice) begin
      period_d = {rc_period[assb_pkg::PERIOD_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      src_tick <= 1'b0;
      bit_period <= '0;
    end else begin
      src_tick <= tick_d;
      bit_period <= period_d;
    end
  end
endmodule : assb_baud_gen

// file: rtl/assb_uart.sv
// buffered asynchronous serial port with apb registers
// How it works
// - holding write sets loaded flag
// - move to shifter clears loaded flag
// - tx status: active bit1, loaded bit0
// - rx status flag layout, zero reset
// - any rx status write clears overrun
// - reading rx holding clears loaded
// - tx irq line1, rx irq line0
// - crystal select 0 uses rc/external
// - external choice picks rc or external
// - crystal select 1 uses enabled crystal
// - rc divisor 16 to 2048, external doubled
// - prescaler 010 gives 4096 and 8192
// - crystal codes give 2400 to 300
// - crystal rate about -2.48 percent slow
// - word length, parity enable, parity mode
// - lsb first, start, parity, one stop
// - tx irq on loaded flag falling
// - stop bit moves word, irq raised
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module assb_uart (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin,
  input wire logic rc_osc_in,
  input wire logic ext_clk_in,
  input wire logic xtal_osc_in,
  output logic tx_pin,
  output logic [1:0] high_priority_irq_line
);
  logic [7:0] ctrl_q;
  logic [7:0] cmd_q;
  logic [7:0] sysclk_q;
  logic [7:0] tx_holding_data_q;
  logic tx_holding_loaded_q;
  logic transmitter_active_q;
  logic [10:0] tx_shift_q;
  logic [3:0] tx_left_q;
  logic [assb_pkg::PERIOD_W-1:0] tx_cnt_q;
  logic [7:0] rx_holding_data_q;
  assb_pkg::assb_rx_sta_t rx_sta_q;
  assb_pkg::assb_rx_state_t rx_state_q;
  logic [assb_pkg::PERIOD_W-1:0] rx_cnt_q;
  logic [3:0] rx_idx_q;
  logic [8:0] rx_shift_q;
  logic rx_serr_q;
  logic rx_s1_q;
  logic rx_s2_q;
  logic rx_s3_q;
  logic src_tick;
  logic [assb_pkg::PERIOD_W-1:0] bit_period;
  assb_pkg::assb_baud_cfg_t baud_cfg;
  logic setup;
  logic access;
  logic wr_txd;
  logic rd_rxd;
  logic wr_rxsta;
  logic tx_load;
  logic tx_bit_end;
  logic rx_bit_end;
  logic rx_half;
  logic rx_done;
  logic [3:0] rx_nbits;
  logic [8:0] rx_aligned;
  logic [7:0] rx_word;
  logic rx_par_bit;
  logic [31:0] rdata_d;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, assb_pkg::ADDR_CTRL) | hit(a, assb_pkg::ADDR_CMD) | hit(a, assb_pkg::ADDR_TXD) |
             hit(a, assb_pkg::ADDR_TXSTA) | hit(a, assb_pkg::ADDR_RXD) | hit(a, assb_pkg::ADDR_RXSTA) |
             hit(a, assb_pkg::ADDR_SYSCLK);
  endfunction : mapped

  // builds start, data, optional parity and stop bits, lsb first
  function automatic logic [10:0] tx_frame(input logic [7:0] data, input logic [7:0] cmd);
    logic [7:0] d;
    logic [3:0] nd;
    d = cmd[assb_pkg::CMD_WL] ? data : {1'b0, data[6:0]};
    nd = cmd[assb_pkg::CMD_WL] ? 4'h8 : 4'h7;
    tx_frame = 11'h7ff;
    tx_frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < nd) begin
        tx_frame[i + 1] = d[i];
      end
    end
    if (cmd[assb_pkg::CMD_PE]) begin
      tx_frame[nd + 4'h1] = ^d ^ cmd[assb_pkg::CMD_PM];
    end
  endfunction : tx_frame

  assign baud_cfg.xtal_sel = cmd_q[assb_pkg::CMD_XSEL];
  assign baud_cfg.ext_choice = sysclk_q[assb_pkg::SYSCLK_EXT];
  assign baud_cfg.xtal_en = sysclk_q[assb_pkg::SYSCLK_XEN];
  assign baud_cfg.rc_presc = cmd_q[assb_pkg::CMD_RCSEL_LSB +: 3];
  assign baud_cfg.rate = ctrl_q[assb_pkg::CTRL_RATE_LSB +: 3];

  assb_baud_gen u_baud (
    .clk(clk),
    .srst(srst),
    .cfg(baud_cfg),
    .osc_pins({xtal_osc_in, ext_clk_in, rc_osc_in}),
    .src_tick(src_tick),
    .bit_period(bit_period)
  );

  // apb: zero wait state, registered answer
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr_txd = access & pwrite & hit(paddr, assb_pkg::ADDR_TXD);
  assign wr_rxsta = access & pwrite & hit(paddr, assb_pkg::ADDR_RXSTA);
  assign rd_rxd = access & ~pwrite & hit(paddr, assb_pkg::ADDR_RXD);

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      assb_pkg::ADDR_CTRL: rdata_d[7:0] = ctrl_q;
      assb_pkg::ADDR_CMD: rdata_d[7:0] = cmd_q;
      assb_pkg::ADDR_TXD: rdata_d[7:0] = tx_holding_data_q;
      assb_pkg::ADDR_TXSTA: rdata_d[1:0] = {transmitter_active_q, tx_holding_loaded_q};
      assb_pkg::ADDR_RXD: rdata_d[7:0] = rx_holding_data_q;
      assb_pkg::ADDR_RXSTA: rdata_d[5:0] = rx_sta_q;
      assb_pkg::ADDR_SYSCLK: rdata_d[1:0] = sysclk_q[1:0];
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped(paddr);
      if (setup & ~pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= assb_pkg::CTRL_RST;
      cmd_q <= assb_pkg::CMD_RST;
      sysclk_q <= assb_pkg::SYSCLK_RST;
      tx_holding_data_q <= assb_pkg::DATA_RST;
    end else if (access & pwrite) begin
      if (hit(paddr, assb_pkg::ADDR_CTRL)) begin
        ctrl_q <= {1'b0, pwdata[6:0]};
      end
      if (hit(paddr, assb_pkg::ADDR_CMD)) begin
        cmd_q <= {pwdata[7], 1'b0, pwdata[5:0]};
      end
      if (hit(paddr, assb_pkg::ADDR_SYSCLK)) begin
        sysclk_q <= {6'h00, pwdata[1:0]};
      end
      if (hit(paddr, assb_pkg::ADDR_TXD)) begin
        tx_holding_data_q <= pwdata[7:0];
      end
    end
  end

  // transmitter
  assign tx_load = ~transmitter_active_q & tx_holding_loaded_q & ctrl_q[assb_pkg::CTRL_ENTX];
  assign tx_bit_end = src_tick & (tx_cnt_q >= bit_period - 1'b1);

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_holding_loaded_q <= 1'b0;
    end else if (wr_txd) begin
      tx_holding_loaded_q <= 1'b1;
    end else if (tx_load) begin
      tx_holding_loaded_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      transmitter_active_q <= 1'b0;
      tx_shift_q <= 11'h7ff;
      tx_left_q <= 4'h0;
      tx_cnt_q <= '0;
    end else if (tx_load) begin
      transmitter_active_q <= 1'b1;
      tx_shift_q <= tx_frame(tx_holding_data_q, cmd_q);
      tx_left_q <= 4'h9 + {3'b000, cmd_q[assb_pkg::CMD_PE]} + {3'b000, cmd_q[assb_pkg::CMD_WL]};
      tx_cnt_q <= '0;
    end else if (transmitter_active_q & src_tick) begin
      if (tx_bit_end) begin
        tx_cnt_q <= '0;
        tx_shift_q <= {1'b1, tx_shift_q[10:1]};
        tx_left_q <= tx_left_q - 4'h1;
        transmitter_active_q <= (tx_left_q != 4'h1);
      end else begin
        tx_cnt_q <= tx_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_pin <= 1'b1;
    end else begin
      tx_pin <= ~transmitter_active_q | tx_shift_q[0];
    end
  end

  // receiver
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end

  assign rx_nbits = 4'h7 + {3'b000, cmd_q[assb_pkg::CMD_WL]} + {3'b000, cmd_q[assb_pkg::CMD_PE]};
  assign rx_bit_end = src_tick & (rx_cnt_q >= bit_period - 1'b1);
  assign rx_half = src_tick & (rx_cnt_q >= (bit_period >> 1) - 1'b1);
  assign rx_done = (rx_state_q == assb_pkg::RX_STOP) & rx_bit_end;
  assign rx_aligned = rx_shift_q >> (4'h9 - rx_nbits);
  assign rx_word = cmd_q[assb_pkg::CMD_WL] ? rx_aligned[7:0] : {1'b0, rx_aligned[6:0]};
  assign rx_par_bit = cmd_q[assb_pkg::CMD_WL] ? rx_aligned[8] : rx_aligned[7];

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_state_q <= assb_pkg::RX_IDLE;
      rx_cnt_q <= '0;
      rx_idx_q <= 4'h0;
      rx_shift_q <= 9'h000;
      rx_serr_q <= 1'b0;
    end else if (~ctrl_q[assb_pkg::CTRL_ENRX]) begin
      rx_state_q <= assb_pkg::RX_IDLE;
    end else begin
      case (rx_state_q)
        assb_pkg::RX_IDLE: begin
          rx_cnt_q <= '0;
          // only a falling edge starts a frame: a line still low after a frame error is no start
          if (~rx_s2_q & rx_s3_q) begin
            rx_state_q <= assb_pkg::RX_START;
          end
        end
        assb_pkg::RX_START: begin
          if (rx_half) begin
            rx_serr_q <= rx_s2_q;
            rx_cnt_q <= '0;
            rx_idx_q <= 4'h0;
            rx_state_q <= assb_pkg::RX_BITS;
          end else if (src_tick) begin
            rx_cnt_q <= rx_cnt_q + 1'b1;
          end
        end
        assb_pkg::RX_BITS: begin
          if (rx_bit_end) begin
            rx_cnt_q <= '0;
            rx_shift_q <= {rx_s2_q, rx_shift_q[8:1]};
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == rx_nbits - 4'h1) begin
              rx_state_q <= assb_pkg::RX_STOP;
            end
          end else if (src_tick) begin
            rx_cnt_q <= rx_cnt_q + 1'b1;
          end
        end
        assb_pkg::RX_STOP: begin
          if (rx_bit_end) begin
            rx_state_q <= assb_pkg::RX_IDLE;
          end else if (src_tick) begin
            rx_cnt_q <= rx_cnt_q + 1'b1;
          end
        end
        default: rx_state_q <= assb_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_holding_data_q <= assb_pkg::DATA_RST;
    end else if (rx_done) begin
      rx_holding_data_q <= rx_word;
    end
  end

  // hardware set wins over a same-cycle software clear
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_sta_q <= '0;
    end else begin
      rx_sta_q.busy <= (rx_state_q != assb_pkg::RX_IDLE) & ctrl_q[assb_pkg::CTRL_ENRX] & ~rx_done;
      if (rx_done) begin
        rx_sta_q.loaded <= 1'b1;
        rx_sta_q.serr <= rx_serr_q;
        rx_sta_q.perr <= cmd_q[assb_pkg::CMD_PE] & (rx_par_bit != (^rx_word ^ cmd_q[assb_pkg::CMD_PM]));
        rx_sta_q.ferr <= ~rx_s2_q;
      end else if (rd_rxd) begin
        rx_sta_q.loaded <= 1'b0;
      end
      if (rx_done & rx_sta_q.loaded & ~rd_rxd) begin
        rx_sta_q.oerr <= 1'b1;
      end else if (wr_rxsta) begin
        rx_sta_q.oerr <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      high_priority_irq_line <= 2'b00;
    end else begin
      high_priority_irq_line[assb_pkg::IRQ_TX_LINE] <= tx_load & ~wr_txd;
      high_priority_irq_line[assb_pkg::IRQ_RX_LINE] <= rx_done;
    end
  end
endmodule : assb_uart

// file: test/assb_uart_sva.sv
// concurrent checks on the serial port pins and apb answers
`timescale 1ns/1ps
module assb_uart_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_pin,
  input wire logic rc_osc_in,
  input wire logic ext_clk_in,
  input wire logic xtal_osc_in,
  input wire logic tx_pin,
  input wire logic [1:0] high_priority_irq_line
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_pready_next: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready too long");
  a_unmapped_err: assert property (psel && !penable && paddr > assb_pkg::ADDR_SYSCLK |=> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && !penable && paddr[1:0] == 2'h0 && paddr <= assb_pkg::ADDR_SYSCLK |=> !pslverr)
    else $error("mapped access refused");
  a_txsta_upper: assert property (psel && penable && !pwrite && paddr == assb_pkg::ADDR_TXSTA |-> prdata[31:2] == 30'h0)
    else $error("tx status upper bits set");
  a_rxsta_upper: assert property (psel && penable && !pwrite && paddr == assb_pkg::ADDR_RXSTA |-> prdata[31:6] == 26'h0)
    else $error("rx status upper bits set");
  a_tx_irq_pulse: assert property (high_priority_irq_line[1] |=> !high_priority_irq_line[1])
    else $error("tx irq not a pulse");
  a_rx_irq_pulse: assert property (high_priority_irq_line[0] |=> !high_priority_irq_line[0])
    else $error("rx irq not a pulse");
  a_tx_start_irq: assert property ($rose(high_priority_irq_line[1]) |-> ##[0:2] !tx_pin)
    else $error("no start bit near tx irq");
  a_tx_low_hold: assert property ($fell(tx_pin) |-> !tx_pin [*8])
    else $error("low bit too short");
  a_tx_high_hold: assert property ($rose(tx_pin) |-> tx_pin [*8])
    else $error("high bit too short");
  a_reset_quiet: assert property (disable iff (1'b0) srst |=> !pready && tx_pin && high_priority_irq_line == 2'h0)
    else $error("outputs active in reset");
endmodule : assb_uart_sva

bind assb_uart assb_uart_sva i_assb_uart_sva (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_pin(rx_pin), .rc_osc_in(rc_osc_in), .ext_clk_in(ext_clk_in), .xtal_osc_in(xtal_osc_in),
  .tx_pin(tx_pin), .high_priority_irq_line(high_priority_irq_line));

// file: test/assb_remote.sv
// remote serial partner: sends frames on the receive line, captures transmit frames
`timescale 1ns/1ps
module assb_remote (
  input wire logic clk,
  input wire logic tx_pin,
  output logic rx_pin
);
  int bit_cyc = 128;
  initial rx_pin = 1'b1;
  // bad[0] flips parity, bad[1] lifts the start bit early, bad[2] drops the stop bit
  task automatic send(input logic [7:0] d, input int n, input logic pe, input logic pm, input logic [2:0] bad);
    logic [10:0] f;
    logic p;
    int k;
    int len;
    p = pm ^ bad[0];
    f = '1;
    f[0] = 1'b0;
    for (k = 0; k < n; k++) begin
      f[k+1] = d[k];
      p = p ^ d[k];
    end
    if (pe) f[n+1] = p;
    len = n + 2 + int'(pe);
    for (k = 0; k < len; k++) begin
      rx_pin <= (k == len - 1) ? !bad[2] : f[k];
      repeat (bit_cyc / 4) @(posedge clk);
      if (k == 0) rx_pin <= bad[1];
      repeat (bit_cyc / 2) @(posedge clk);
      if (k == len - 1) rx_pin <= 1'b1;
      repeat (bit_cyc - 3 * (bit_cyc / 4)) @(posedge clk);
    end
  endtask : send
  // mid-bit sampling absorbs a few percent of rate error
  task automatic capture(input int n, output logic [10:0] f);
    int k;
    f = '0;
    @(negedge tx_pin);
    repeat (bit_cyc / 2) @(posedge clk);
    for (k = 0; k < n; k++) begin
      f[k] = tx_pin;
      if (k < n - 1) repeat (bit_cyc) @(posedge clk);
    end
  endtask : capture
endmodule : assb_remote

// file: test/async_serial_status_and_baud_bench.sv
// self-checking bench for the serial port with baud generator
`timescale 1ns/1ps
module async_serial_status_and_baud_bench;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, rx_pin, tx_pin;
  logic rc_osc_in, ext_clk_in, xtal_osc_in, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [1:0] high_priority_irq_line;
  logic [10:0] f;
  int err_total = 0;
  int checks = 0;
  int irq_n[2] = '{0, 0};
  int i;
  logic [7:0] rst_tab[7] = '{8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] err_sta[4] = '{8'h11, 8'h21, 8'h09, 8'h01};
  logic [2:0] err_bad[4] = '{3'h1, 3'h2, 3'h4, 3'h0};
  logic [23:0] baud_cfg[3] = '{24'h670100, 24'h670101, 24'h638102};
  int baud_cyc[3] = '{128, 128, 70};

  assb_uart i_assb_uart (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
    .rc_osc_in(rc_osc_in), .ext_clk_in(ext_clk_in), .xtal_osc_in(xtal_osc_in), .tx_pin(tx_pin),
    .high_priority_irq_line(high_priority_irq_line));
  assb_remote i_assb_remote (.clk(clk), .tx_pin(tx_pin), .rx_pin(rx_pin));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // source oscillators run free, in fixed phase with clk; external runs at twice the rc rate
  initial begin
    rc_osc_in = 1'b0;
    ext_clk_in = 1'b0;
    xtal_osc_in = 1'b0;
    fork
      forever #200 rc_osc_in = ~rc_osc_in;
      forever #100 ext_clk_in = ~ext_clk_in;
      forever #125 xtal_osc_in = ~xtal_osc_in;
    join
  end
  always @(posedge clk) begin
    if (high_priority_irq_line[0] === 1'b1) irq_n[0]++;
    if (high_priority_irq_line[1] === 1'b1) irq_n[1]++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic wait_irq(input int idx, input int want);
    int k;
    k = 0;
    while (irq_n[idx] < want && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk(32'(irq_n[idx]), 32'(want));
  endtask : wait_irq
  task automatic rx(input logic [7:0] d, input int n, input logic pe, input logic pm, input logic [2:0] bad);
    int c;
    c = irq_n[0];
    i_assb_remote.send(d, n, pe, pm, bad);
    wait_irq(0, c + 1);
  endtask : rx
  task automatic tx_frame(input logic [7:0] d, input logic [31:0] exp);
    fork
      i_assb_remote.capture(10, f);
      wr(assb_pkg::ADDR_TXD, {24'h0, d});
    join
    chk({21'h0, f}, exp);
  endtask : tx_frame
  task automatic complete_run;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    complete_run;
  end
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 7; i++) rd(8'(i * 4), {24'h0, rst_tab[i]});
    rd(8'h20, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    wr(assb_pkg::ADDR_CTRL, 32'h67);
    fork
      i_assb_remote.capture(10, f);
      begin
        wr(assb_pkg::ADDR_TXD, 32'ha5);
        wait_irq(1, 1);
        wr(assb_pkg::ADDR_TXD, 32'h3c);
        rd(assb_pkg::ADDR_TXSTA, 32'h3);
      end
    join
    chk({21'h0, f}, {22'h0, 1'b1, 8'ha5, 1'b0});
    fork
      i_assb_remote.capture(10, f);
      begin
        wait_irq(1, 2);
        rd(assb_pkg::ADDR_TXSTA, 32'h2);
      end
    join
    chk({21'h0, f}, {22'h0, 1'b1, 8'h3c, 1'b0});
    rx(8'h5a, 8, 1'b0, 1'b0, 3'h0);
    rd(assb_pkg::ADDR_RXSTA, 32'h1);
    rd(assb_pkg::ADDR_RXD, 32'h5a);
    rd(assb_pkg::ADDR_RXSTA, 32'h0);
    rx(8'h11, 8, 1'b0, 1'b0, 3'h0);
    rx(8'h22, 8, 1'b0, 1'b0, 3'h0);
    rd(assb_pkg::ADDR_RXSTA, 32'h5);
    rd(assb_pkg::ADDR_RXD, 32'h22);
    wr(assb_pkg::ADDR_RXSTA, 32'hff);
    rd(assb_pkg::ADDR_RXSTA, 32'h0);
    wr(assb_pkg::ADDR_CMD, 32'h06);
    tx_frame(8'hff, {22'h0, 1'b1, 1'b0, 7'h7f, 1'b0});
    for (i = 0; i < 4; i++) begin
      rx(8'hff, 7, 1'b1, 1'b1, err_bad[i]);
      rd(assb_pkg::ADDR_RXSTA, {24'h0, err_sta[i]});
      rd(assb_pkg::ADDR_RXD, 32'h7f);
    end
    wr(assb_pkg::ADDR_CMD, 32'h03);
    rx(8'hc3, 8, 1'b1, 1'b0, 3'h0);
    rd(assb_pkg::ADDR_RXSTA, 32'h1);
    rd(assb_pkg::ADDR_RXD, 32'hc3);
    for (i = 0; i < 3; i++) begin
      wr(assb_pkg::ADDR_CTRL, {24'h0, baud_cfg[i][23:16]});
      wr(assb_pkg::ADDR_CMD, {24'h0, baud_cfg[i][15:8]});
      wr(assb_pkg::ADDR_SYSCLK, {24'h0, baud_cfg[i][7:0]});
      i_assb_remote.bit_cyc = baud_cyc[i];
      tx_frame(8'h96, {22'h0, 1'b1, 8'h96, 1'b0});
    end
    chk(32'(irq_n[1]), 32'd6);
    chk(32'(irq_n[0]), 32'd8);
    complete_run;
  end
endmodule : async_serial_status_and_baud_bench
